// >>> core/dsd_addr_gen.sv
// Effective address and pointer update for one load/store request.
`timescale 1ns/10ps
module dsd_addr_gen (
  // Request
  input wire dsd_pkg::dsd_req_t req,
  input wire logic [15:0] ptr_val,
  // Result
  output logic [15:0] eff_addr,
  output logic ptr_upd,
  output logic [15:0] ptr_new
);

  always_comb begin
    eff_addr = ptr_val;
    ptr_upd = 1'b0;
    ptr_new = ptr_val;
    case (req.mode)
      dsd_pkg::MODE_DIRECT: begin
        eff_addr = req.addr;
      end
      dsd_pkg::MODE_DISP: begin
        // The first pointer carries no displacement; it acts as plain indirect.
        // unsigned displacement add
        if (req.ptr != dsd_pkg::PTR_A) begin
          eff_addr = ptr_val + {10'h000, req.disp};
        end
      end
      dsd_pkg::MODE_PREDEC: begin
        eff_addr = ptr_val - 16'h0001;
        ptr_upd = 1'b1;
        ptr_new = ptr_val - 16'h0001;
      end
      dsd_pkg::MODE_POSTINC: begin
        ptr_upd = 1'b1;
        ptr_new = ptr_val + 16'h0001;
      end
      default: begin
        eff_addr = ptr_val;
      end
    endcase
  end

endmodule

// >>> core/dsd_data_space.sv
// Data-space decoder top: working registers, SRAM, I/O and USB access steering.
// Notes on behaviour
// - The lowest 608 addresses hold working registers, I/O registers and SRAM.
// - First 96 addresses are registers plus I/O; next 512 are SRAM bytes.
// - Addresses 0 to 31 read and write the working registers directly.
// - I/O register n also answers at data address n plus 0x20.
// - Five modes: direct, indirect, displacement, pre-decrement, post-increment.
// - Direct mode reaches every data address, the USB window included.
// - The top six working registers form the three 16-bit pointers.
// - Displacement adds an unsigned 0 to 63 offset to the second or third pointer.
// - Pre-decrement writes back pointer minus one; post-increment pointer plus one.
// - Every mode reaches all working registers, I/O registers and SRAM bytes.
// - Listed USB register addresses in 0x1F00 to 0x1FFF go to the USB register block; other offsets there answer unmapped.
`timescale 1ns/10ps
module dsd_data_space #(
  parameter int SRAM_DEPTH = dsd_pkg::SRAM_BYTES
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Load/store request
  input wire logic REQ_VALID,
  input wire dsd_pkg::dsd_req_t REQ,
  output logic REQ_READY,
  // Load/store answer
  output logic RSP_VALID,
  output logic [7:0] RSP_RDATA,
  output logic RSP_UNMAPPED,
  output dsd_pkg::dsd_region_t RSP_REGION,
  // I/O register port
  output logic IO_EN,
  output logic IO_WRITE,
  output logic [5:0] IO_ADDR,
  output logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  // USB register port
  output logic USB_EN,
  output logic USB_WRITE,
  output logic [7:0] USB_ADDR,
  output logic [7:0] USB_WDATA,
  input wire logic [7:0] USB_RDATA
);

  // ------------------------------------------------------------
  // Storage and pipeline state
  // ------------------------------------------------------------
  logic [7:0] gpr_q [dsd_pkg::GPR_COUNT];
  logic [7:0] sram_q [SRAM_DEPTH];
  dsd_pkg::dsd_acc_t acc_q;
  dsd_pkg::dsd_acc_t acc_d;
  logic acc_vld_q;
  logic ready_q;
  logic take;

  logic [4:0] ptr_lo_idx;
  logic [4:0] ptr_hi_idx;
  logic [15:0] ptr_val;
  logic [15:0] eff_addr;
  logic ptr_upd;
  logic [15:0] ptr_new;
  dsd_pkg::dsd_region_t region;

  logic [4:0] gpr_idx;
  logic [8:0] sram_idx;
  logic [15:0] sram_off;
  logic [7:0] rd_data;

  assign take = REQ_VALID && ready_q;

  // ------------------------------------------------------------
  // Pointer selection
  // ------------------------------------------------------------
  // pointer byte pairs
  always_comb begin
    case (REQ.ptr)
      dsd_pkg::PTR_B: begin
        ptr_lo_idx = dsd_pkg::POINTER_B_LOW_REG;
        ptr_hi_idx = dsd_pkg::POINTER_B_HIGH_REG;
      end
      dsd_pkg::PTR_C: begin
        ptr_lo_idx = dsd_pkg::POINTER_C_LOW_REG;
        ptr_hi_idx = dsd_pkg::POINTER_C_HIGH_REG;
      end
      default: begin
        ptr_lo_idx = dsd_pkg::POINTER_A_LOW_REG;
        ptr_hi_idx = dsd_pkg::POINTER_A_HIGH_REG;
      end
    endcase
  end

  assign ptr_val = {gpr_q[ptr_hi_idx], gpr_q[ptr_lo_idx]};

  // ------------------------------------------------------------
  // Address generation and decode
  // ------------------------------------------------------------
  // all five addressing modes
  dsd_addr_gen u_addr_gen (
    .req(REQ),
    .ptr_val(ptr_val),
    .eff_addr(eff_addr),
    .ptr_upd(ptr_upd),
    .ptr_new(ptr_new)
  );

  dsd_region_dec u_region_dec (
    .addr(eff_addr),
    .region(region)
  );

  // ------------------------------------------------------------
  // Request acceptance
  // ------------------------------------------------------------
  // One request every other cycle, so a store to a pointer byte has
  // landed before the next request reads that pointer.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= !take;
    end
  end

  always_comb begin
    acc_d.region = region;
    acc_d.addr = eff_addr;
    acc_d.write = REQ.write;
    acc_d.wdata = REQ.wdata;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      acc_vld_q <= 1'b0;
      acc_q.region <= dsd_pkg::REG_NONE;
      acc_q.addr <= 16'h0000;
      acc_q.write <= 1'b0;
      acc_q.wdata <= 8'h00;
    end else begin
      acc_vld_q <= take;
      if (take) begin
        acc_q <= acc_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Index arithmetic for the accepted access
  // ------------------------------------------------------------
  // working register at its own address
  assign gpr_idx = acc_q.addr[4:0];
  // SRAM byte index past the register and I/O block
  assign sram_off = acc_q.addr - dsd_pkg::SRAM_BASE;
  assign sram_idx = sram_off[8:0];

  // ------------------------------------------------------------
  // Working register file with pointer write-back
  // ------------------------------------------------------------
  // A data store lands one cycle after the pointer update, so a store
  // that targets a pointer byte overwrites the auto-updated value.
  genvar gi;
  generate
    for (gi = 0; gi < dsd_pkg::GPR_COUNT; gi++) begin : g_gpr
      always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
          gpr_q[gi] <= dsd_pkg::GPR_RESET;
        end else if (acc_vld_q && acc_q.write && acc_q.region == dsd_pkg::REG_GPR
                     && gpr_idx == 5'(gi)) begin
          gpr_q[gi] <= acc_q.wdata;
        end else if (take && ptr_upd && ptr_lo_idx == 5'(gi)) begin
          gpr_q[gi] <= ptr_new[7:0];
        end else if (take && ptr_upd && ptr_hi_idx == 5'(gi)) begin
          gpr_q[gi] <= ptr_new[15:8];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Internal SRAM
  // ------------------------------------------------------------
  // Data storage is left unreset; software must initialise it.
  always_ff @(posedge CORE_CLK) begin
    if (acc_vld_q && acc_q.write && acc_q.region == dsd_pkg::REG_SRAM) begin
      sram_q[sram_idx] <= acc_q.wdata;
    end
  end

  // ------------------------------------------------------------
  // I/O register strobes
  // ------------------------------------------------------------
  // The strobe is raised in the cycle after acceptance and the peripheral
  // answers combinationally in that same cycle.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      IO_EN <= 1'b0;
      IO_WRITE <= 1'b0;
      IO_ADDR <= 6'h00;
      IO_WDATA <= 8'h00;
    end else begin
      // I/O register reached through the data space
      IO_EN <= take && region == dsd_pkg::REG_IO;
      IO_WRITE <= take && region == dsd_pkg::REG_IO && REQ.write;
      if (take && region == dsd_pkg::REG_IO) begin
        IO_ADDR <= 6'(eff_addr - dsd_pkg::IO_BASE);
        IO_WDATA <= REQ.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // USB register strobes
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      USB_EN <= 1'b0;
      USB_WRITE <= 1'b0;
      USB_ADDR <= 8'h00;
      USB_WDATA <= 8'h00;
    end else begin
      // window goes to the USB block
      // unassigned offsets never raise the strobe
      USB_EN <= take && region == dsd_pkg::REG_USB;
      USB_WRITE <= take && region == dsd_pkg::REG_USB && REQ.write;
      if (take && region == dsd_pkg::REG_USB) begin
        USB_ADDR <= eff_addr[7:0];
        USB_WDATA <= REQ.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Read data steering
  // ------------------------------------------------------------
  // contiguous map from address zero to 0x25F; the USB window at 0x1F00 stands apart
  always_comb begin
    rd_data = 8'h00;
    if (acc_q.region == dsd_pkg::REG_GPR) begin
      rd_data = gpr_q[gpr_idx];
    end else if (acc_q.region == dsd_pkg::REG_IO) begin
      rd_data = IO_RDATA;
    end else if (acc_q.region == dsd_pkg::REG_SRAM) begin
      rd_data = sram_q[sram_idx];
    end else if (acc_q.region == dsd_pkg::REG_USB) begin
      rd_data = USB_RDATA;
    end else begin
      rd_data = 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Answer
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 8'h00;
      RSP_UNMAPPED <= 1'b0;
      RSP_REGION <= dsd_pkg::REG_NONE;
    end else begin
      RSP_VALID <= acc_vld_q;
      if (acc_vld_q) begin
        RSP_RDATA <= acc_q.write ? 8'h00 : rd_data;
        RSP_UNMAPPED <= acc_q.region == dsd_pkg::REG_NONE;
        RSP_REGION <= acc_q.region;
      end
    end
  end

  // Accept indicator is a register so the core sees it from a flop.
  assign REQ_READY = ready_q;

endmodule

// >>> core/dsd_pkg.sv
// Shared constants, enumerations and carrier types of the data-space decoder.
package dsd_pkg;

  // ------------------------------------------------------------
  // Data space layout
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] GPR_BASE = 16'h0000;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] SRAM_END = 16'h0260;
  localparam logic [15:0] USB_BASE = 16'h1F00;
  localparam logic [15:0] USB_LAST = 16'h1FFF;
  localparam int GPR_COUNT = 32;
  localparam int IO_COUNT = 64;
  localparam int SRAM_BYTES = 512;
  localparam int DISP_W = 6;

  // ------------------------------------------------------------
  // Pointer register positions in the working register file
  // ------------------------------------------------------------
  localparam logic [4:0] POINTER_A_LOW_REG = 5'h1A;
  localparam logic [4:0] POINTER_A_HIGH_REG = 5'h1B;
  localparam logic [4:0] POINTER_B_LOW_REG = 5'h1C;
  localparam logic [4:0] POINTER_B_HIGH_REG = 5'h1D;
  localparam logic [4:0] POINTER_C_LOW_REG = 5'h1E;
  localparam logic [4:0] POINTER_C_HIGH_REG = 5'h1F;
  localparam logic [7:0] GPR_RESET = 8'h00;

  // ------------------------------------------------------------
  // USB register window, byte addresses
  // ------------------------------------------------------------
  localparam logic [15:0] FUNCTION_EP2_CONTROL_ACK = 16'h1FA3;
  localparam logic [15:0] FUNCTION_EP1_CONTROL_ACK = 16'h1FA4;
  localparam logic [15:0] FUNCTION_EP0_CONTROL_ACK = 16'h1FA5;
  localparam logic [15:0] HUB_EP0_CONTROL_ACK = 16'h1FA7;
  localparam logic [15:0] HUB_PORT2_BUS_STATE = 16'h1FA9;
  localparam logic [15:0] HUB_PORT3_BUS_STATE = 16'h1FAA;
  localparam logic [15:0] HUB_PORT1_CHANGE_FLAGS = 16'h1FB0;
  localparam logic [15:0] HUB_PORT2_CHANGE_FLAGS = 16'h1FB1;
  localparam logic [15:0] HUB_PORT3_CHANGE_FLAGS = 16'h1FB2;
  localparam logic [15:0] HUB_PORT1_CONDITION = 16'h1FB8;
  localparam logic [15:0] HUB_PORT2_CONDITION = 16'h1FB9;
  localparam logic [15:0] HUB_PORT3_CONDITION = 16'h1FBA;
  localparam logic [15:0] HUB_PORT_COMMAND = 16'h1FC5;
  localparam logic [15:0] HUB_CONDITION = 16'h1FC7;
  localparam logic [15:0] FUNCTION_EP2_BYTE_COUNT = 16'h1FCB;
  localparam logic [15:0] FUNCTION_EP1_BYTE_COUNT = 16'h1FCC;
  localparam logic [15:0] FUNCTION_EP0_BYTE_COUNT = 16'h1FCD;
  localparam logic [15:0] HUB_EP0_BYTE_COUNT = 16'h1FCF;
  localparam logic [15:0] FUNCTION_EP2_FIFO_PORT = 16'h1FD3;
  localparam logic [15:0] FUNCTION_EP1_FIFO_PORT = 16'h1FD4;
  localparam logic [15:0] FUNCTION_EP0_FIFO_PORT = 16'h1FD5;
  localparam logic [15:0] HUB_EP0_FIFO_PORT = 16'h1FD7;
  localparam logic [15:0] FUNCTION_EP2_SERVICE_FLAGS = 16'h1FDB;
  localparam logic [15:0] FUNCTION_EP1_SERVICE_FLAGS = 16'h1FDC;
  localparam logic [15:0] FUNCTION_EP0_SERVICE_FLAGS = 16'h1FDD;
  localparam logic [15:0] HUB_EP0_SERVICE_FLAGS = 16'h1FDF;
  localparam logic [15:0] FUNCTION_EP2_SETUP = 16'h1FE3;
  localparam logic [15:0] FUNCTION_EP1_SETUP = 16'h1FE4;
  localparam logic [15:0] FUNCTION_EP0_SETUP = 16'h1FE5;
  localparam logic [15:0] HUB_EP0_SETUP = 16'h1FE7;
  localparam logic [15:0] FUNCTION_DEVICE_ADDRESS = 16'h1FEE;
  localparam logic [15:0] HUB_DEVICE_ADDRESS = 16'h1FEF;
  localparam logic [15:0] OVERCURRENT_DETECT = 16'h1FF2;
  localparam logic [15:0] USB_IRQ_ENABLE = 16'h1FF3;
  localparam logic [15:0] USB_IRQ_ACKNOWLEDGE = 16'h1FF5;
  localparam logic [15:0] USB_IRQ_MASK = 16'h1FF6;
  localparam logic [15:0] USB_IRQ_PENDING = 16'h1FF7;
  localparam logic [15:0] SUSPEND_RESUME_IRQ_MASK = 16'h1FF8;
  localparam logic [15:0] SUSPEND_RESUME_IRQ_ENABLE = 16'h1FF9;
  localparam logic [15:0] SUSPEND_RESUME_FLAGS = 16'h1FFA;
  localparam logic [15:0] GLOBAL_USB_CONDITION = 16'h1FFB;
  localparam logic [15:0] FRAME_COUNT_LOW = 16'h1FFC;
  localparam logic [15:0] FRAME_COUNT_HIGH = 16'h1FFD;

  // ------------------------------------------------------------
  // Enumerations and carriers
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_DIRECT = 5'h01,
    MODE_INDIRECT = 5'h02,
    MODE_DISP = 5'h04,
    MODE_PREDEC = 5'h08,
    MODE_POSTINC = 5'h10
  } dsd_mode_t;

  typedef enum logic [2:0] {
    PTR_A = 3'h1,
    PTR_B = 3'h2,
    PTR_C = 3'h4
  } dsd_ptr_t;

  typedef enum logic [4:0] {
    REG_GPR = 5'h01,
    REG_IO = 5'h02,
    REG_SRAM = 5'h04,
    REG_USB = 5'h08,
    REG_NONE = 5'h10
  } dsd_region_t;

  typedef struct packed {
    dsd_mode_t mode;
    dsd_ptr_t ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic write;
    logic [7:0] wdata;
  } dsd_req_t;

  typedef struct packed {
    dsd_region_t region;
    logic [15:0] addr;
    logic write;
    logic [7:0] wdata;
  } dsd_acc_t;

endpackage

// >>> core/dsd_region_dec.sv
// Region decode of a data-space address, including the USB register list.
`timescale 1ns/10ps
module dsd_region_dec (
  // Address in
  input wire logic [15:0] addr,
  // Decode out
  output dsd_pkg::dsd_region_t region
);

  logic usb_known;

  always_comb begin
    case (addr)
      dsd_pkg::FUNCTION_EP2_CONTROL_ACK, dsd_pkg::FUNCTION_EP1_CONTROL_ACK,
      dsd_pkg::FUNCTION_EP0_CONTROL_ACK, dsd_pkg::HUB_EP0_CONTROL_ACK,
      dsd_pkg::HUB_PORT2_BUS_STATE, dsd_pkg::HUB_PORT3_BUS_STATE,
      dsd_pkg::HUB_PORT1_CHANGE_FLAGS, dsd_pkg::HUB_PORT2_CHANGE_FLAGS,
      dsd_pkg::HUB_PORT3_CHANGE_FLAGS, dsd_pkg::HUB_PORT1_CONDITION,
      dsd_pkg::HUB_PORT2_CONDITION, dsd_pkg::HUB_PORT3_CONDITION,
      dsd_pkg::HUB_PORT_COMMAND, dsd_pkg::HUB_CONDITION,
      dsd_pkg::FUNCTION_EP2_BYTE_COUNT, dsd_pkg::FUNCTION_EP1_BYTE_COUNT,
      dsd_pkg::FUNCTION_EP0_BYTE_COUNT, dsd_pkg::HUB_EP0_BYTE_COUNT,
      dsd_pkg::FUNCTION_EP2_FIFO_PORT, dsd_pkg::FUNCTION_EP1_FIFO_PORT,
      dsd_pkg::FUNCTION_EP0_FIFO_PORT, dsd_pkg::HUB_EP0_FIFO_PORT,
      dsd_pkg::FUNCTION_EP2_SERVICE_FLAGS, dsd_pkg::FUNCTION_EP1_SERVICE_FLAGS,
      dsd_pkg::FUNCTION_EP0_SERVICE_FLAGS, dsd_pkg::HUB_EP0_SERVICE_FLAGS,
      dsd_pkg::FUNCTION_EP2_SETUP, dsd_pkg::FUNCTION_EP1_SETUP,
      dsd_pkg::FUNCTION_EP0_SETUP, dsd_pkg::HUB_EP0_SETUP,
      dsd_pkg::FUNCTION_DEVICE_ADDRESS, dsd_pkg::HUB_DEVICE_ADDRESS,
      dsd_pkg::OVERCURRENT_DETECT, dsd_pkg::USB_IRQ_ENABLE,
      dsd_pkg::USB_IRQ_ACKNOWLEDGE, dsd_pkg::USB_IRQ_MASK,
      dsd_pkg::USB_IRQ_PENDING, dsd_pkg::SUSPEND_RESUME_IRQ_MASK,
      dsd_pkg::SUSPEND_RESUME_IRQ_ENABLE, dsd_pkg::SUSPEND_RESUME_FLAGS,
      dsd_pkg::GLOBAL_USB_CONDITION, dsd_pkg::FRAME_COUNT_LOW,
      dsd_pkg::FRAME_COUNT_HIGH: usb_known = 1'b1;
      default: usb_known = 1'b0;
    endcase
  end

  always_comb begin
    if (addr < dsd_pkg::IO_BASE) begin
      region = dsd_pkg::REG_GPR;
    end else if (addr < dsd_pkg::SRAM_BASE) begin
      region = dsd_pkg::REG_IO;
    end else if (addr < dsd_pkg::SRAM_END) begin
      region = dsd_pkg::REG_SRAM;
    end else if (addr >= dsd_pkg::USB_BASE && addr <= dsd_pkg::USB_LAST && usb_known) begin
      region = dsd_pkg::REG_USB;
    end else begin
      region = dsd_pkg::REG_NONE;
    end
  end

endmodule

// >>> sim/dsd_data_space_props.sv
// Port-level assertion checker for the data-space decoder top.
`timescale 1ns/10ps
module dsd_data_space_props #(
  parameter int SRAM_DEPTH = 512
) (
  // Clock and reset
  input logic CORE_CLK,
  input logic RST_B,
  // Request and answer
  input logic REQ_VALID,
  input dsd_pkg::dsd_req_t REQ,
  input logic REQ_READY,
  input logic RSP_VALID,
  input logic [7:0] RSP_RDATA,
  input logic RSP_UNMAPPED,
  input dsd_pkg::dsd_region_t RSP_REGION,
  // Peripheral ports
  input logic IO_EN,
  input logic [5:0] IO_ADDR,
  input logic USB_EN,
  input logic USB_WRITE,
  input logic [7:0] USB_ADDR,
  input logic [7:0] USB_RDATA
);
  logic take;
  logic dir;
  logic [5:0] io_num;
  logic [15:0] sram_top;
  assign take = REQ_VALID && REQ_READY;
  assign dir = take && REQ.mode == dsd_pkg::MODE_DIRECT;
  assign io_num = REQ.addr[5:0] - 6'h20;
  assign sram_top = 16'h0060 + 16'(SRAM_DEPTH) - 16'h0001;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  // ------------------------------------------------------------
  // Request timing
  // ------------------------------------------------------------
  sequence s_answer;
    ##1 !RSP_VALID ##1 RSP_VALID;
  endsequence
  sequence s_gap_answer;
    ##1 (!IO_EN && !USB_EN) ##1 (RSP_VALID && RSP_UNMAPPED && RSP_RDATA == 8'h00);
  endsequence

  AST_ANSWER_TWO: assert property (take |-> s_answer)
    else $error("answer not two cycles after take");
  AST_READY_GAP: assert property (take |=> !REQ_READY)
    else $error("ready stayed high after take");

  // ------------------------------------------------------------
  // Region steering
  // ------------------------------------------------------------
  // I/O alias offset.
  AST_IO_ALIAS: assert property (
    dir && REQ.addr inside {[16'h0020:16'h005F]} |=> IO_EN && IO_ADDR == $past(io_num))
    else $error("I/O strobe or number wrong");
  AST_USB_STROBE: assert property (
    dir && !REQ.write && REQ.addr == dsd_pkg::USB_IRQ_PENDING
    |=> USB_EN && !USB_WRITE && USB_ADDR == 8'hF7)
    else $error("USB strobe missing for listed register");
  AST_USB_DATA: assert property (USB_EN && !USB_WRITE |=>
    RSP_VALID && RSP_RDATA == $past(USB_RDATA))
    else $error("USB read data not returned");
  AST_GAP_QUIET: assert property (
    dir && REQ.addr inside {[16'h0260:16'h1EFF]} |-> s_gap_answer)
    else $error("gap access touched a port or read nonzero");
  AST_SRAM_REGION: assert property (
    dir && REQ.addr >= 16'h0060 && REQ.addr <= sram_top
    |-> ##2 RSP_REGION == dsd_pkg::REG_SRAM)
    else $error("SRAM address not answered as SRAM");
  AST_GPR_REGION: assert property (
    dir && REQ.addr < 16'h0020 |-> ##2 RSP_REGION == dsd_pkg::REG_GPR && !RSP_UNMAPPED)
    else $error("register address not answered as register");
endmodule

bind dsd_data_space dsd_data_space_props #(.SRAM_DEPTH(SRAM_DEPTH)) u_dsd_data_space_props (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID), .REQ(REQ),
  .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
  .RSP_UNMAPPED(RSP_UNMAPPED), .RSP_REGION(RSP_REGION), .IO_EN(IO_EN),
  .IO_ADDR(IO_ADDR), .USB_EN(USB_EN), .USB_WRITE(USB_WRITE), .USB_ADDR(USB_ADDR),
  .USB_RDATA(USB_RDATA)
);

// >>> sim/dsd_data_space_tb_top.sv
// Self-checking testbench for the data-space decoder.
`timescale 1ns/10ps
module dsd_data_space_tb_top;
  logic CORE_CLK;
  logic RST_B;
  logic REQ_VALID;
  dsd_pkg::dsd_req_t REQ;
  logic REQ_READY, RSP_VALID, RSP_UNMAPPED, IO_EN, IO_WRITE, USB_EN, USB_WRITE;
  logic [7:0] RSP_RDATA, IO_WDATA, IO_RDATA, USB_ADDR, USB_WDATA, USB_RDATA;
  logic [5:0] IO_ADDR;
  dsd_pkg::dsd_region_t RSP_REGION;
  dsd_pkg::dsd_region_t rg;
  logic [7:0] rd;
  logic um;
  int err_total = 0;
  int samples_checked = 0;

  dsd_data_space u_dsd_data_space (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .RSP_UNMAPPED(RSP_UNMAPPED), .RSP_REGION(RSP_REGION), .IO_EN(IO_EN),
    .IO_WRITE(IO_WRITE), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
    .USB_EN(USB_EN), .USB_WRITE(USB_WRITE), .USB_ADDR(USB_ADDR),
    .USB_WDATA(USB_WDATA), .USB_RDATA(USB_RDATA)
  );
  dsd_periph_model u_dsd_periph_model (
    .clk(CORE_CLK), .io_en(IO_EN), .io_write(IO_WRITE), .io_addr(IO_ADDR),
    .io_wdata(IO_WDATA), .io_rdata(IO_RDATA), .usb_en(USB_EN), .usb_write(USB_WRITE),
    .usb_addr(USB_ADDR), .usb_wdata(USB_WDATA), .usb_rdata(USB_RDATA)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Holds the request until a cycle with ready, then samples the answer two cycles on.
  task automatic acc(input dsd_pkg::dsd_mode_t m, input dsd_pkg::dsd_ptr_t p,
      input logic [5:0] d, input logic [15:0] a, input logic w, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{mode: m, ptr: p, disp: d, addr: a, write: w, wdata: wd};
    @(negedge CORE_CLK);
    while (REQ_READY !== 1'b1 && n < 20) begin
      @(negedge CORE_CLK);
      n++;
    end
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b0;
    @(negedge CORE_CLK);
    @(negedge CORE_CLK);
    rd = RSP_RDATA;
    rg = RSP_REGION;
    um = RSP_UNMAPPED;
    chk("answer", {15'h0, RSP_VALID}, 16'h0001);
  endtask

  task automatic dw(input logic [15:0] a, input logic [7:0] d);
    acc(dsd_pkg::MODE_DIRECT, dsd_pkg::PTR_A, 6'h00, a, 1'b1, d);
  endtask

  task automatic dr(input logic [15:0] a);
    acc(dsd_pkg::MODE_DIRECT, dsd_pkg::PTR_A, 6'h00, a, 1'b0, 8'h00);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Register file base.
  task automatic sc_gpr();
    dw(16'h0005, 8'h5A);
    dr(16'h0005);
    chk("gpr byte", {8'h0, rd}, 16'h005A);
    chk("gpr region", {11'h0, rg}, {11'h0, dsd_pkg::REG_GPR});
  endtask

  task automatic sc_io();
    dr(16'h0020);
    chk("io first", {8'h0, rd}, 16'h00C3);
    dr(16'h005F);
    chk("io last", {8'h0, rd}, 16'h00FC);
    chk("io region", {11'h0, rg}, {11'h0, dsd_pkg::REG_IO});
    dw(16'h0041, 8'h77);
    dr(16'h0041);
    chk("io store", {8'h0, rd}, 16'h0077);
  endtask

  task automatic sc_sram();
    dw(16'h0060, 8'h11);
    dw(16'h025F, 8'h22);
    dr(16'h0060);
    chk("sram first", {8'h0, rd}, 16'h0011);
    chk("sram region", {11'h0, rg}, {11'h0, dsd_pkg::REG_SRAM});
    dr(16'h025F);
    chk("sram last", {8'h0, rd}, 16'h0022);
    dw(16'h00FF, 8'h5C);
    dw(16'h1EFF, 8'hFF);
    dr(16'h1EFF);
    chk("gap read", {7'h0, um, rd}, 16'h0100);
    dr(16'h00FF);
    chk("gap alias", {8'h0, rd}, 16'h005C);
    dr(16'h0260);
    chk("gap start", {7'h0, um, rd}, 16'h0100);
  endtask

  task automatic sc_usb();
    logic [15:0] lst [4];
    lst = '{dsd_pkg::USB_IRQ_PENDING, dsd_pkg::FRAME_COUNT_HIGH,
            dsd_pkg::FUNCTION_EP2_CONTROL_ACK, dsd_pkg::HUB_DEVICE_ADDRESS};
    foreach (lst[i]) begin
      dr(lst[i]);
      chk("usb read", {8'h0, rd}, {8'h0, lst[i][7:0] ^ 8'h3C});
      chk("usb region", {11'h0, rg}, {11'h0, dsd_pkg::REG_USB});
    end
    dw(dsd_pkg::FUNCTION_DEVICE_ADDRESS, 8'h42);
    dr(dsd_pkg::FUNCTION_DEVICE_ADDRESS);
    chk("usb store", {8'h0, rd}, 16'h0042);
    dr(16'h1F00);
    chk("usb hole", {7'h0, um, rd}, 16'h0100);
    dr(16'h1FFF);
    chk("usb top hole", {7'h0, um, rd}, 16'h0100);
  endtask

  task automatic sc_ptr();
    dw(16'h001E, 8'h60);
    dw(16'h001F, 8'h00);
    acc(dsd_pkg::MODE_POSTINC, dsd_pkg::PTR_C, 6'h00, 16'h0000, 1'b1, 8'h33);
    dr(16'h001E);
    chk("ptr after inc", {8'h0, rd}, 16'h0061);
    dr(16'h0060);
    chk("inc store", {8'h0, rd}, 16'h0033);
    acc(dsd_pkg::MODE_PREDEC, dsd_pkg::PTR_C, 6'h00, 16'h0000, 1'b0, 8'h00);
    chk("dec load", {8'h0, rd}, 16'h0033);
    dr(16'h001E);
    chk("ptr after dec", {8'h0, rd}, 16'h0060);
    dw(16'h001C, 8'h60);
    dw(16'h001D, 8'h00);
    acc(dsd_pkg::MODE_DISP, dsd_pkg::PTR_B, 6'h3F, 16'h0000, 1'b1, 8'h44);
    dr(16'h009F);
    chk("disp store", {8'h0, rd}, 16'h0044);
    acc(dsd_pkg::MODE_DISP, dsd_pkg::PTR_C, 6'h3F, 16'h0000, 1'b0, 8'h00);
    chk("disp third load", {8'h0, rd}, 16'h0044);
    dw(16'h001A, 8'h3F);
    dw(16'h001B, 8'h00);
    acc(dsd_pkg::MODE_INDIRECT, dsd_pkg::PTR_A, 6'h00, 16'h0000, 1'b0, 8'h00);
    chk("indirect io", {8'h0, rd}, 16'h00DC);
    chk("indirect region", {11'h0, rg}, {11'h0, dsd_pkg::REG_IO});
    acc(dsd_pkg::MODE_DISP, dsd_pkg::PTR_A, 6'h01, 16'h0000, 1'b0, 8'h00);
    chk("disp first ignored", {8'h0, rd}, 16'h00DC);
  endtask

  initial begin
    RST_B = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    repeat (3) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    sc_gpr();
    sc_io();
    sc_sram();
    sc_usb();
    sc_ptr();
    give_verdict();
  end

  // 39 accesses of under ten cycles each; over ten times that is ample.
  initial begin
    #50000;
    err_total++;
    give_verdict();
  end
endmodule

// >>> sim/dsd_periph_model.sv
// Behavioural I/O and USB register responder on the decoder's peripheral ports.
`timescale 1ns/10ps
module dsd_periph_model (
  // Clock
  input logic clk,
  // I/O register port
  input logic io_en,
  input logic io_write,
  input logic [5:0] io_addr,
  input logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // USB register port
  input logic usb_en,
  input logic usb_write,
  input logic [7:0] usb_addr,
  input logic [7:0] usb_wdata,
  output logic [7:0] usb_rdata
);
  logic [7:0] io_mem [64];
  logic [7:0] usb_mem [256];
  logic [7:0] idle_q = 8'hA5;
  initial begin
    for (int i = 0; i < 256; i++) begin
      usb_mem[i] = 8'(i) ^ 8'h3C;
      if (i < 64) begin
        io_mem[i] = 8'(i) ^ 8'hC3;
      end
    end
  end
  always @(posedge clk) begin
    idle_q <= ~idle_q;
    if (io_en && io_write) begin
      io_mem[io_addr] <= io_wdata;
    end
    if (usb_en && usb_write) begin
      usb_mem[usb_addr] <= usb_wdata;
    end
  end
  // Without a strobe the read buses toggle, so stale data can never pass for an answer.
  assign io_rdata = io_en ? io_mem[io_addr] : idle_q;
  assign usb_rdata = usb_en ? usb_mem[usb_addr] : ~idle_q;
endmodule
